// file: verilog/cgl_regs.sv
// Clock guard control, write lock and interrupt registers on the bus
`timescale 1ns/100ps
`default_nettype none
module cgl_regs #(
  parameter int SWITCH_CYCLES = cgl_pkg::CGL_SWITCH_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Peripheral bus, one access per cycle with sel high
  input wire logic pb_sel_i,
  input wire logic pb_write_i,
  input wire logic [9:0] pb_addr_i,
  input wire logic [31:0] pb_wdata_i,
  output logic [31:0] pb_rdata_o,
  // Clock monitors and select-register write from the clock selector
  input wire logic clock_loss_det_i,
  input wire logic overfreq_det_i,
  input wire logic clock_select_write_i,
  // Clock fallback and interrupt
  output logic use_rc_osc_o,
  output logic overfreq_flag_o,
  output logic loss_detect_en_o,
  output logic overfreq_guard_en_o,
  output logic irq_o
);
  import cgl_pkg::*;

  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] mask_reg, mask_next;
  logic [31:0] pend_reg, pend_next;
  logic [31:0] stat_reg, stat_next;
  logic [31:0] rdata_reg, rdata_next;
  logic unl_vld_reg, unl_vld_next;
  logic [9:0] unl_addr_reg, unl_addr_next;
  logic [7:0] sw_cnt_reg, sw_cnt_next;
  logic rc_reg, rc_next;
  logic ovf_reg, ovf_next;
  logic irq_reg, irq_next;

  logic wr;
  logic prot_hit;
  logic granted;
  logic [31:0] evt;

  always_comb begin
    wr = pb_sel_i && pb_write_i;
    // Only the control register is lock protected here
    prot_hit = wr && (pb_addr_i == CGL_OFS_FDCTRL);
    granted = unl_vld_reg && (unl_addr_reg == pb_addr_i);
  end

  // Unlock grant: armed by a keyed write, spent by the next access
  always_comb begin
    unl_vld_next = unl_vld_reg;
    unl_addr_next = unl_addr_reg;
    if (pb_sel_i) begin
      unl_vld_next = 1'b0;
      if (wr && pb_addr_i == CGL_OFS_UNLOCK &&
          pb_wdata_i[31:24] == CGL_UNLOCK_KEY) begin
        unl_vld_next = 1'b1;
        unl_addr_next = pb_wdata_i[9:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      unl_vld_reg <= 1'b0;
      unl_addr_reg <= 10'h000;
    end else begin
      unl_vld_reg <= unl_vld_next;
      unl_addr_reg <= unl_addr_next;
    end
  end

  // Control register with freeze
  always_comb begin
    ctrl_next = ctrl_reg;
    if (prot_hit && granted && !ctrl_reg[CGL_BIT_FREEZE]) begin
      ctrl_next = CGL_RST_ZERO;
      ctrl_next[CGL_BIT_FREEZE] = pb_wdata_i[CGL_BIT_FREEZE];
      ctrl_next[CGL_BIT_OVFEN] = pb_wdata_i[CGL_BIT_OVFEN];
      ctrl_next[CGL_BIT_LOSSEN] = pb_wdata_i[CGL_BIT_LOSSEN];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= CGL_RST_ZERO;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Clock switch settling: ready drops on select write, returns later
  always_comb begin
    sw_cnt_next = sw_cnt_reg;
    if (clock_select_write_i) begin
      sw_cnt_next = 8'(SWITCH_CYCLES);
    end else if (sw_cnt_reg != 8'h00) begin
      sw_cnt_next = sw_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sw_cnt_reg <= 8'h00;
    end else begin
      sw_cnt_reg <= sw_cnt_next;
    end
  end

  // Fallback to the RC oscillator, held until reset
  always_comb begin
    rc_next = rc_reg;
    ovf_next = ovf_reg;
    if (ctrl_reg[CGL_BIT_LOSSEN] && clock_loss_det_i) begin
      rc_next = 1'b1;
    end
    if (ctrl_reg[CGL_BIT_OVFEN] && overfreq_det_i) begin
      rc_next = 1'b1;
      ovf_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rc_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      rc_reg <= rc_next;
      ovf_reg <= ovf_next;
    end
  end

  // Status and event bits
  always_comb begin
    evt = CGL_RST_ZERO;
    evt[CGL_BIT_LOSS] = ctrl_reg[CGL_BIT_LOSSEN] && clock_loss_det_i &&
                        !stat_reg[CGL_BIT_LOSS];
    // Ready rises when the settle count reaches its end
    evt[CGL_BIT_RDY] = (sw_cnt_reg == 8'h01) && !clock_select_write_i;
    evt[CGL_BIT_AE] = prot_hit && !granted;
    stat_next = stat_reg;
    stat_next[CGL_BIT_LOSS] = stat_reg[CGL_BIT_LOSS] | evt[CGL_BIT_LOSS];
    stat_next[CGL_BIT_AE] = stat_reg[CGL_BIT_AE] | evt[CGL_BIT_AE];
    if (clock_select_write_i) begin
      stat_next[CGL_BIT_RDY] = 1'b0;
    end else if (evt[CGL_BIT_RDY]) begin
      stat_next[CGL_BIT_RDY] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      stat_reg <= CGL_RST_ZERO;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Mask and pending registers; set beats clear on the same cycle
  always_comb begin
    mask_next = mask_reg;
    pend_next = pend_reg;
    if (wr && pb_addr_i == CGL_OFS_IER) begin
      mask_next = mask_reg | (pb_wdata_i & CGL_EVT_MASK);
    end
    if (wr && pb_addr_i == CGL_OFS_IDR) begin
      mask_next = mask_reg & ~(pb_wdata_i & CGL_EVT_MASK);
    end
    if (wr && pb_addr_i == CGL_OFS_ICR) begin
      pend_next = pend_reg & ~(pb_wdata_i & CGL_EVT_MASK);
    end
    pend_next = pend_next | (evt & CGL_EVT_MASK);
    irq_next = |(pend_next & mask_next);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mask_reg <= CGL_RST_ZERO;
      pend_reg <= CGL_RST_ZERO;
      irq_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      pend_reg <= pend_next;
      irq_reg <= irq_next;
    end
  end

  // Read data, registered one cycle after the read
  always_comb begin
    rdata_next = CGL_RST_ZERO;
    if (pb_sel_i && !pb_write_i) begin
      unique case (pb_addr_i)
        CGL_OFS_FDCTRL: rdata_next = ctrl_reg;
        CGL_OFS_IMR: rdata_next = mask_reg;
        CGL_OFS_ISR: rdata_next = pend_reg;
        CGL_OFS_SR: rdata_next = stat_reg;
        default: rdata_next = CGL_RST_ZERO;
      endcase
    end
  end

  // Read data drops back to zero when no read is taken
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= CGL_RST_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign pb_rdata_o = rdata_reg;
  assign use_rc_osc_o = rc_reg;
  assign overfreq_flag_o = ovf_reg;
  assign loss_detect_en_o = ctrl_reg[CGL_BIT_LOSSEN];
  assign overfreq_guard_en_o = ctrl_reg[CGL_BIT_OVFEN];
  assign irq_o = irq_reg;
endmodule : cgl_regs
`default_nettype wire

// file: verilog/cgl_pkg.sv
// Constants for the clock guard, unlock and interrupt register group
package cgl_pkg;
  localparam logic [9:0] CGL_OFS_FDCTRL = 10'h054;
  localparam logic [9:0] CGL_OFS_UNLOCK = 10'h058;
  localparam logic [9:0] CGL_OFS_IER = 10'h0c0;
  localparam logic [9:0] CGL_OFS_IDR = 10'h0c4;
  localparam logic [9:0] CGL_OFS_IMR = 10'h0c8;
  localparam logic [9:0] CGL_OFS_ISR = 10'h0cc;
  localparam logic [9:0] CGL_OFS_ICR = 10'h0d0;
  localparam logic [9:0] CGL_OFS_SR = 10'h0d4;
  localparam int CGL_BIT_FREEZE = 31;
  localparam int CGL_BIT_OVFEN = 1;
  localparam int CGL_BIT_LOSSEN = 0;
  localparam int CGL_BIT_AE = 31;
  localparam int CGL_BIT_RDY = 5;
  localparam int CGL_BIT_LOSS = 0;
  localparam logic [7:0] CGL_UNLOCK_KEY = 8'haa;
  localparam logic [31:0] CGL_RST_ZERO = 32'h00000000;
  localparam logic [31:0] CGL_EVT_MASK = 32'h80000021;
  localparam int CGL_SWITCH_CYCLES = 4;
endpackage : cgl_pkg

// file: testbench/cgl_regs_monitor.sv
// Port checker for the clock guard register group
`timescale 1ns/100ps
`default_nettype none
module cgl_regs_monitor (
  // Clock, reset and bus
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic pb_sel_i,
  input wire logic pb_write_i,
  input wire logic [9:0] pb_addr_i,
  input wire logic [31:0] pb_wdata_i,
  // Monitors and outputs
  input wire logic clock_loss_det_i,
  input wire logic overfreq_det_i,
  input wire logic use_rc_osc_o,
  input wire logic overfreq_flag_o,
  input wire logic loss_detect_en_o,
  input wire logic overfreq_guard_en_o,
  input wire logic irq_o
);
  import cgl_pkg::*;
  logic wr_ctl;
  logic spend;
  logic off_all;
  assign wr_ctl = pb_sel_i && pb_write_i && pb_addr_i == CGL_OFS_FDCTRL;
  // Any access but a write to the unlock register counts as spend; the design also spends the grant on an unkeyed unlock write
  assign spend = pb_sel_i && !(pb_write_i && pb_addr_i == CGL_OFS_UNLOCK);
  assign off_all = pb_sel_i && pb_write_i && pb_addr_i == CGL_OFS_IDR &&
    pb_wdata_i == CGL_EVT_MASK;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_LOSS_EN_CAUSE: assert property (
    $changed(loss_detect_en_o) |-> $past(wr_ctl)) else $error("loss en");
  AST_OVF_EN_CAUSE: assert property (
    $changed(overfreq_guard_en_o) |-> $past(wr_ctl)) else $error("ovf en");
  AST_CTL_DISCARD: assert property (
    wr_ctl && $past(spend) |=> $stable(loss_detect_en_o) &&
    $stable(overfreq_guard_en_o)) else $error("unlocked write landed");
  AST_RC_LOSS: assert property (
    clock_loss_det_i && loss_detect_en_o |=> use_rc_osc_o)
    else $error("no fallback on loss");
  AST_RC_OVF: assert property (
    overfreq_det_i && overfreq_guard_en_o |=> overfreq_flag_o && use_rc_osc_o)
    else $error("no fallback on overfrequency");
  AST_RC_CAUSE: assert property (
    $rose(use_rc_osc_o) |-> $past(clock_loss_det_i && loss_detect_en_o ||
    overfreq_det_i && overfreq_guard_en_o)) else $error("fallback cause");
  AST_OVF_STICKY: assert property (
    overfreq_flag_o |=> overfreq_flag_o) else $error("flag dropped");
  AST_IRQ_OFF: assert property (
    off_all ##1 !pb_sel_i |-> ##1 !irq_o) else $error("irq while disabled");
endmodule : cgl_regs_monitor
bind cgl_regs cgl_regs_monitor MON (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .pb_sel_i(pb_sel_i), .pb_write_i(pb_write_i), .pb_addr_i(pb_addr_i),
  .pb_wdata_i(pb_wdata_i), .clock_loss_det_i(clock_loss_det_i),
  .overfreq_det_i(overfreq_det_i), .use_rc_osc_o(use_rc_osc_o),
  .overfreq_flag_o(overfreq_flag_o), .loss_detect_en_o(loss_detect_en_o),
  .overfreq_guard_en_o(overfreq_guard_en_o), .irq_o(irq_o));
`default_nettype wire

// file: testbench/test_cgl_regs.sv
// Register-level testbench for the clock guard register group
`timescale 1ns/100ps
`default_nettype none
module test_cgl_regs;
  import cgl_pkg::*;
  localparam int SW = 4;
  logic ref_clk_i, rstn_i, sel, wr, cs, ld, od;
  logic [9:0] ad;
  logic [31:0] wd, rd_o;
  logic rc, of, le, ge, irq;
  int failures = 0;
  int n_tests = 0;
  cgl_regs #(.SWITCH_CYCLES(SW)) DUT (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .pb_sel_i(sel), .pb_write_i(wr), .pb_addr_i(ad),
    .pb_wdata_i(wd), .pb_rdata_o(rd_o), .clock_loss_det_i(ld),
    .overfreq_det_i(od), .clock_select_write_i(cs), .use_rc_osc_o(rc),
    .overfreq_flag_o(of), .loss_detect_en_o(le), .overfreq_guard_en_o(ge),
    .irq_o(irq));
  task give_verdict;
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task chkb(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask : chkb
  // Called at a rising edge; leaves the strobe up for back-to-back use
  task acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    sel <= 1'b1; wr <= w; ad <= a; wd <= d;
    @(posedge ref_clk_i);
  endtask : acc
  task idle(input int n);
    sel <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask : idle
  task rd(input logic [9:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    sel <= 1'b0;
    #1 chk("rdata", e, rd_o);
    @(posedge ref_clk_i);
  endtask : rd
  task unl;
    acc(1'b1, CGL_OFS_UNLOCK, {CGL_UNLOCK_KEY, 14'h0, CGL_OFS_FDCTRL});
  endtask : unl
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    failures++;
    give_verdict();
  end
  initial begin
    rstn_i = 0; sel = 0; wr = 0; cs = 0; ld = 0; od = 0; ad = 0; wd = 0;
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(CGL_OFS_FDCTRL, 32'h0);
    rd(CGL_OFS_IMR, 32'h0);
    rd(CGL_OFS_ISR, 32'h0);
    rd(CGL_OFS_SR, 32'h0);
    rd(10'h3fc, 32'h0);
    acc(1'b1, CGL_OFS_FDCTRL, 32'h3);
    idle(1);
    rd(CGL_OFS_FDCTRL, 32'h0);
    rd(CGL_OFS_SR, 32'h80000000);
    unl();
    acc(1'b1, CGL_OFS_FDCTRL, 32'h3);
    idle(2);
    chkb("loss_en", 1'b1, le);
    chkb("guard_en", 1'b1, ge);
    acc(1'b1, CGL_OFS_UNLOCK, 32'h55000054);
    acc(1'b1, CGL_OFS_FDCTRL, 32'h0);
    unl();
    acc(1'b0, CGL_OFS_IMR, 32'h0);
    acc(1'b1, CGL_OFS_FDCTRL, 32'h0);
    idle(1);
    rd(CGL_OFS_FDCTRL, 32'h3);
    acc(1'b1, CGL_OFS_IER, CGL_EVT_MASK);
    idle(2);
    chkb("irq", 1'b1, irq);
    rd(CGL_OFS_IMR, 32'h80000021);
    acc(1'b1, CGL_OFS_IDR, 32'h1);
    acc(1'b1, CGL_OFS_ICR, 32'h80000000);
    idle(1);
    rd(CGL_OFS_IMR, 32'h80000020);
    rd(CGL_OFS_ISR, 32'h0);
    cs <= 1'b1;
    @(posedge ref_clk_i);
    cs <= 1'b0;
    rd(CGL_OFS_SR, 32'h80000000);
    idle(SW + 2);
    rd(CGL_OFS_SR, 32'h80000020);
    chkb("irq", 1'b1, irq);
    acc(1'b1, CGL_OFS_IDR, CGL_EVT_MASK);
    idle(3);
    chkb("irq", 1'b0, irq);
    ld <= 1'b1;
    idle(2);
    chkb("rc", 1'b1, rc);
    rd(CGL_OFS_ISR, 32'h21);
    od <= 1'b1;
    idle(2);
    chkb("ovf", 1'b1, of);
    unl();
    acc(1'b1, CGL_OFS_FDCTRL, 32'h80000000);
    unl();
    acc(1'b1, CGL_OFS_FDCTRL, 32'h3);
    idle(1);
    rd(CGL_OFS_FDCTRL, 32'h80000000);
    give_verdict();
  end
endmodule : test_cgl_regs
`default_nettype wire
